/* File: rtl/host_port_defines.vh */
// register map, word fields and timing constants of the host port
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define A_ISO_CTRL 5'h01
`define A_OPT_B 5'h02
`define A_OPT_HBR 5'h03
`define A_PULSE_LEN 5'h05
`define A_MOD_CTRL 5'h09
`define A_REG_IO 5'h0B
`define A_IRQ_STAT 5'h0C
`define A_FIFO_STAT 5'h1C
`define A_TX_LEN_HI 5'h1D
`define A_TX_LEN_LO 5'h1E
`define A_FIFO 5'h1F
`define AW_CMD 7
`define AW_READ 6
`define AW_CONT 5
`define CMD_FIFO_RESET 5'h0F
`define CMD_TRANSMIT 5'h11
`define STRAP_SPI_SS 3'b110
`define STRAP_SPI_NOSS 3'b100
`define IRQ_TX_BIT 7
`define IRQ_FIFO_BIT 5
`define ISO_DIRECT_BIT 6
`define ISO_B_BIT 3
`define MOD_ANALOG_BIT 3
`define IO_EXT_PA_BIT 6
`define LEN_PART_BIT 0
`define OPT_B_NO_SOF 0
`define OPT_B_NO_EOF 1
`define OPT_B_EGT_LSB 2
`define OPT_B_EGT_MSB 3
`define HBR_NO_PARITY 0
`define HBR_TXRATE_LSB 5
`define HBR_TXRATE_MSB 6
`define PRESET_OPT_B 8'h00
`define PRESET_OPT_HBR 8'h00
`define PRESET_PULSE_LEN 8'h00
`define REG_RESET 8'h00
`define FIFO_CNT_FIELD_W 7
`define FIFO_LOW_LEVEL 4
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define TX_BIT_NS 9440
`define CLK_NS 50
`endif

/* File: rtl/reader_host_port_tx_start.v */
// host port (parallel or spi), register file, data fifo and transmit start logic
//
// Contract
// - default mode adds SOF, EOF, parity and CRC to sent frames automatically.
// - writing protocol register reloads all transmit parameter registers with presets.
// - length and data loaded first: transmission starts when transmit command arrives.
// - command and length first: transmission starts at first FIFO data byte.
// - long frames raise FIFO level interrupt while draining; host refills FIFO.
// - transmission end sets TX-complete status bit and asserts interrupt request.
// - complete byte count is length-high byte plus upper nibble of length-low.
// - length-low B0 flags partial byte; B1..B3 give its bit count.
// - option registers pick B SOF/EOF/EGT, tx rate and parity method.
// - regulator/io B6 gives modulated output for external amplifier, external rx input.
// - modulation register B3 selects digital (0) or analog (1) modulation pin.
// - host port runs as parallel bus or SPI, never both.
// - strap pins sampled at reset select SPI with or without slave select.
// - device is slave only; interrupt pin requests service in both modes.
// - during SPI read, indicator pin high for the 8 data clocks.
// - each transaction opens with start condition then one 8-bit address/command word.
// - word B7 address/command, B6 read, B5 continuous, B4..B0 code.
// - continuous mode accesses given address, then increments per further word; the code holds the address at the FIFO address 1Fh.
// - non-continuous mode accepts exactly one data word after address.
// - parallel direct mode outputs bit stream and bit strobe on neighbouring pins.
`timescale 1ns/10ps
`include "host_port_defines.vh"

module tx_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter CW = $clog2(D + 1)
) (
  input wire clk,
  input wire srst,
  input wire clr,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready,
  output wire [CW-1:0] count
);
  localparam AW = (D > 1) ? $clog2(D) : 1;
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [CW-1:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_r != D[CW-1:0]);
  assign out_valid = (cnt_r != {CW{1'b0}});
  assign out_data = mem_r[rp_r];
  assign count = cnt_r;
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (srst || clr) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {CW{1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
    end
  end
endmodule // tx_fifo

////////////////////////////////////////////////////////////////////////////////

module reader_host_port_tx_start #(
  parameter FIFO_DEPTH = 16,
  parameter TX_BIT_CYC = `TX_BIT_NS / `CLK_NS
) (
  input wire core_clk,
  input wire srst,
  input wire data_clk,
  input wire [7:0] io_in,
  output reg [7:0] io_out,
  output reg [7:0] io_oe,
  output reg irq,
  output reg tx_bit,
  output reg tx_strobe,
  output reg tx_sof,
  output reg tx_eof,
  output reg tx_busy,
  output reg ext_mod,
  output reg rx_ext_sel,
  output reg mod_analog
);
  localparam CW = $clog2(FIFO_DEPTH + 1);
  localparam P_ADDR = 4'b0001;
  localparam P_WDATA = 4'b0010;
  localparam P_RDATA = 4'b0100;
  localparam P_IGN = 4'b1000;
  localparam T_IDLE = 5'b00001;
  localparam T_SOF = 5'b00010;
  localparam T_LOAD = 5'b00100;
  localparam T_BITS = 5'b01000;
  localparam T_EOF = 5'b10000;
  localparam [15:0] BIT_CYC = TX_BIT_CYC;

  // pins cross into core_clk through two stages; stage 3 only serves edge detection and the clock-high check
  reg dclk_s1, dclk_s2, dclk_s3;
  reg [7:0] io_s1, io_s2, io_s3;
  always @(posedge core_clk) begin
    dclk_s1 <= data_clk;
    dclk_s2 <= dclk_s1;
    dclk_s3 <= dclk_s2;
    io_s1 <= io_in;
    io_s2 <= io_s1;
    io_s3 <= io_s2;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture and interface mode
  reg strap_done_r, spi_ss_r, spi_noss_r;
  always @(posedge core_clk) begin
    if (srst) begin
      strap_done_r <= 1'b0;
      spi_ss_r <= 1'b0;
      spi_noss_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      spi_ss_r <= (io_s2[2:0] == `STRAP_SPI_SS);
      spi_noss_r <= (io_s2[2:0] == `STRAP_SPI_NOSS);
    end
  end
  // any other strap pattern leaves the port in parallel mode
  wire spi = spi_ss_r | spi_noss_r;

  ////////////////////////////////////////////////////////////////////////////////
  // transaction framing and byte assembly
  wire clk_rise = dclk_s2 & ~dclk_s3;
  wire clk_fall = ~dclk_s2 & dclk_s3;
  wire clk_high = dclk_s2 & dclk_s3;
  wire d7_rise = io_s2[7] & ~io_s3[7];
  wire d7_fall = ~io_s2[7] & io_s3[7];
  wire ss_high = io_s2[4];
  wire start_c = spi_ss_r ? (io_s3[4] & ~ss_high) : (d7_rise & clk_high);
  wire stop_c = spi_ss_r ? (~io_s3[4] & ss_high) : (d7_fall & clk_high);
  reg sess_r;
  reg [3:0] ph_r;
  reg [2:0] bc_r;
  reg [7:0] shin_r;
  reg [7:0] shout_r;
  reg miso_r;
  reg [4:0] addr_r;
  reg cont_r;
  wire in_rise = sess_r & clk_rise & ~(spi_ss_r & ss_high);
  wire in_fall = sess_r & clk_fall & ~(spi_ss_r & ss_high);
  wire byte_done = in_rise & (~spi | (bc_r == 3'd7));
  wire [7:0] byte_val = spi ? {shin_r[6:0], io_s2[7]} : io_s2;
  wire in_addr = byte_done & (ph_r == P_ADDR);
  wire is_cmd = in_addr & byte_val[`AW_CMD];
  wire fifo_clr = is_cmd & (byte_val[4:0] == `CMD_FIFO_RESET);
  wire cmd_tx = is_cmd & (byte_val[4:0] == `CMD_TRANSMIT);
  wire wr_en = byte_done & (ph_r == P_WDATA);
  wire [4:0] nxt_addr = (addr_r == `A_FIFO) ? addr_r : addr_r + 5'd1;
  wire rd_first = in_addr & ~byte_val[`AW_CMD] & byte_val[`AW_READ];
  wire rd_load = rd_first | (byte_done & (ph_r == P_RDATA) & cont_r);
  wire [4:0] rd_addr = rd_first ? byte_val[4:0] : nxt_addr;

  always @(posedge core_clk) begin
    if (srst) begin
      sess_r <= 1'b0;
      ph_r <= P_IGN;
      bc_r <= 3'd0;
      shin_r <= 8'h00;
      addr_r <= 5'h00;
      cont_r <= 1'b0;
    end else if (start_c) begin
      sess_r <= 1'b1;
      ph_r <= P_ADDR;
      bc_r <= 3'd0;
    end else if (stop_c) begin
      sess_r <= 1'b0;
      ph_r <= P_IGN;
    end else if (in_rise) begin
      bc_r <= bc_r + 3'd1;
      shin_r <= {shin_r[6:0], io_s2[7]};
      if (byte_done) begin
        case (ph_r)
          P_ADDR: begin
            addr_r <= byte_val[4:0];
            cont_r <= byte_val[`AW_CONT];
            if (byte_val[`AW_CMD]) begin
              ph_r <= P_IGN;
            end else if (byte_val[`AW_READ]) begin
              ph_r <= P_RDATA;
            end else begin
              ph_r <= P_WDATA;
            end
          end
          P_WDATA, P_RDATA: begin
            if (cont_r) begin
              addr_r <= nxt_addr;
            end else begin
              ph_r <= P_IGN;
            end
          end
          default: ph_r <= P_IGN;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  reg [7:0] regs_r [0:31];
  reg [7:0] irq_stat_r;
  reg ovf_r;
  reg [7:0] rd_val;
  integer i;
  wire [CW-1:0] fifo_cnt;
  wire fifo_in_ready;
  wire fifo_push = wr_en & (addr_r == `A_FIFO);
  always @* begin
    case (rd_addr)
      `A_IRQ_STAT: rd_val = irq_stat_r;
      `A_FIFO_STAT: rd_val = {ovf_r, {(`FIFO_CNT_FIELD_W-CW){1'b0}}, fifo_cnt};
      `A_FIFO: rd_val = 8'h00;
      default: rd_val = regs_r[rd_addr];
    endcase
  end
  always @(posedge core_clk) begin
    if (srst) begin
      for (i = 0; i < 32; i = i + 1) begin
        regs_r[i] <= `REG_RESET;
      end
    end else if (wr_en && addr_r != `A_FIFO && addr_r != `A_IRQ_STAT &&
                 addr_r != `A_FIFO_STAT) begin
      regs_r[addr_r] <= byte_val;
      if (addr_r == `A_ISO_CTRL) begin
        regs_r[`A_OPT_B] <= `PRESET_OPT_B;
        regs_r[`A_OPT_HBR] <= `PRESET_OPT_HBR;
        regs_r[`A_PULSE_LEN] <= `PRESET_PULSE_LEN;
      end
    end
  end
  // overflow is sticky until the fifo reset command; a full fifo drops the byte
  always @(posedge core_clk) begin
    if (srst || fifo_clr) begin
      ovf_r <= 1'b0;
    end else if (fifo_push && !fifo_in_ready) begin
      ovf_r <= 1'b1;
    end
  end

  // read shifter: loaded at the address word, shifted on falling clocks in spi
  always @(posedge core_clk) begin
    if (srst) begin
      shout_r <= 8'h00;
      miso_r <= 1'b0;
    end else if (rd_load) begin
      shout_r <= rd_val;
    end else if (spi && in_fall && ph_r == P_RDATA) begin
      miso_r <= shout_r[7];
      shout_r <= {shout_r[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data fifo
  wire fifo_valid;
  wire [7:0] fifo_data;
  reg fifo_pop_r;
  tx_fifo #(
    .W(8),
    .D(FIFO_DEPTH),
    .CW(CW)
  ) u_fifo (
    .clk(core_clk),
    .srst(srst),
    .clr(fifo_clr),
    .in_valid(fifo_push),
    .in_data(byte_val),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop_r),
    .count(fifo_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter
  wire [7:0] iso = regs_r[`A_ISO_CTRL];
  wire [7:0] opt_b = regs_r[`A_OPT_B];
  wire [7:0] opt_hbr = regs_r[`A_OPT_HBR];
  wire [7:0] len_lo = regs_r[`A_TX_LEN_LO];
  wire framing = ~iso[`ISO_DIRECT_BIT];
  wire is_b = iso[`ISO_B_BIT];
  wire sof_en = framing & ~(is_b & opt_b[`OPT_B_NO_SOF]);
  wire eof_en = framing & ~(is_b & opt_b[`OPT_B_NO_EOF]);
  wire par_en = framing & ~opt_hbr[`HBR_NO_PARITY];
  wire [15:0] per_cyc = BIT_CYC >> opt_hbr[`HBR_TXRATE_MSB:`HBR_TXRATE_LSB];
  wire [15:0] per_load = (per_cyc == 16'h0000) ? 16'h0000 : per_cyc - 16'h0001;
  wire [11:0] len12 = {regs_r[`A_TX_LEN_HI], len_lo[7:4]};
  reg [4:0] ts_r;
  reg [15:0] tmr_r;
  reg [11:0] left_r;
  reg part_r;
  reg [2:0] part_bits_r;
  reg [8:0] sh_r;
  reg [3:0] nbits_r;
  reg [3:0] dbits_r;
  reg [15:0] crc_r;
  reg [1:0] crc_ph_r;
  reg [1:0] egt_r;
  reg arm_r;
  reg low_prev_r;
  wire tick = (tmr_r == 16'h0000);
  wire start_tx = arm_r & fifo_valid & (ts_r == T_IDLE);
  wire crc_fb = crc_r[0] ^ sh_r[0];
  wire tx_done = (ts_r == T_EOF && tick) ||
                 (ts_r == T_LOAD && left_r == 12'h000 && !part_r &&
                  !(framing && crc_ph_r != 2'd2) && !eof_en);
  wire [12:0] remain = {1'b0, left_r} + {12'h000, part_r};
  // a byte being popped has already left left_r; counting it as queued too
  // would drop low_now for one cycle and raise the fifo flag a second time
  wire [CW-1:0] queued = fifo_cnt - {{(CW-1){1'b0}}, fifo_pop_r};
  // level irq only while sending and more data is still owed than is queued
  wire low_now = (ts_r != T_IDLE) && (queued < `FIFO_LOW_LEVEL) &&
                 (remain > {{(13-CW){1'b0}}, queued});

  always @(posedge core_clk) begin
    if (srst || fifo_clr) begin
      arm_r <= 1'b0;
    end else if (cmd_tx) begin
      arm_r <= 1'b1;
    end else if (start_tx) begin
      arm_r <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      ts_r <= T_IDLE;
      tmr_r <= 16'h0000;
      left_r <= 12'h000;
      part_r <= 1'b0;
      part_bits_r <= 3'd0;
      sh_r <= 9'h000;
      nbits_r <= 4'd0;
      dbits_r <= 4'd0;
      crc_r <= `CRC_INIT;
      crc_ph_r <= 2'd0;
      egt_r <= 2'd0;
      fifo_pop_r <= 1'b0;
      tx_bit <= 1'b0;
      tx_strobe <= 1'b0;
    end else begin
      fifo_pop_r <= 1'b0;
      tx_strobe <= 1'b0;
      tmr_r <= tick ? per_load : tmr_r - 16'h0001;
      case (ts_r)
        T_IDLE: begin
          if (start_tx) begin
            left_r <= len12;
            part_r <= len_lo[`LEN_PART_BIT];
            part_bits_r <= len_lo[3:1];
            crc_r <= `CRC_INIT;
            crc_ph_r <= framing ? 2'd0 : 2'd2;
            tmr_r <= per_load;
            ts_r <= sof_en ? T_SOF : T_LOAD;
          end
        end
        T_SOF: begin
          if (tick) begin
            ts_r <= T_LOAD;
          end
        end
        T_LOAD: begin
          if (!fifo_pop_r && left_r != 12'h000) begin
            if (fifo_valid) begin
              fifo_pop_r <= 1'b1;
              sh_r <= {~^fifo_data, fifo_data};
              nbits_r <= par_en ? 4'd9 : 4'd8;
              dbits_r <= 4'd8;
              left_r <= left_r - 12'h001;
              ts_r <= T_BITS;
            end
          end else if (!fifo_pop_r && part_r) begin
            if (fifo_valid) begin
              fifo_pop_r <= 1'b1;
              sh_r <= {1'b0, fifo_data};
              nbits_r <= {1'b0, part_bits_r};
              dbits_r <= {1'b0, part_bits_r};
              part_r <= 1'b0;
              ts_r <= T_BITS;
            end
          end else if (!fifo_pop_r && crc_ph_r != 2'd2) begin
            sh_r <= crc_ph_r[0] ? {~^crc_r[15:8], crc_r[15:8]} : {~^crc_r[7:0], crc_r[7:0]};
            nbits_r <= par_en ? 4'd9 : 4'd8;
            dbits_r <= 4'd0;
            crc_ph_r <= crc_ph_r + 2'd1;
            ts_r <= T_BITS;
          end else if (!fifo_pop_r) begin
            ts_r <= eof_en ? T_EOF : T_IDLE;
          end
          egt_r <= is_b ? opt_b[`OPT_B_EGT_MSB:`OPT_B_EGT_LSB] : 2'd0;
        end
        T_BITS: begin
          if (tick) begin
            if (nbits_r != 4'd0) begin
              tx_bit <= sh_r[0];
              tx_strobe <= 1'b1;
              sh_r <= {1'b0, sh_r[8:1]};
              nbits_r <= nbits_r - 4'd1;
              if (dbits_r != 4'd0) begin
                dbits_r <= dbits_r - 4'd1;
                crc_r <= (crc_r >> 1) ^ (crc_fb ? `CRC_POLY : 16'h0000);
              end
            end else if (egt_r != 2'd0) begin
              tx_bit <= 1'b0;
              egt_r <= egt_r - 2'd1;
            end else begin
              tx_bit <= 1'b0;
              ts_r <= T_LOAD;
            end
          end
        end
        T_EOF: begin
          if (tick) begin
            ts_r <= T_IDLE;
          end
        end
        default: ts_r <= T_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status and interrupt; a new event beats a read-clear in the same cycle
  wire rd_clr = rd_load & (rd_addr == `A_IRQ_STAT);
  always @(posedge core_clk) begin
    if (srst) begin
      irq_stat_r <= 8'h00;
      low_prev_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      low_prev_r <= low_now;
      irq_stat_r <= (rd_clr ? 8'h00 : irq_stat_r) |
                    ({7'h00, tx_done} << `IRQ_TX_BIT) |
                    ({7'h00, low_now & ~low_prev_r} << `IRQ_FIFO_BIT);
      irq <= |irq_stat_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers
  wire rd_phase = (ph_r == P_RDATA) & sess_r;
  wire direct = iso[`ISO_DIRECT_BIT];
  always @(posedge core_clk) begin
    if (srst) begin
      io_out <= 8'h00;
      io_oe <= 8'h00;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
      tx_busy <= 1'b0;
      ext_mod <= 1'b0;
      rx_ext_sel <= 1'b0;
      mod_analog <= 1'b0;
    end else begin
      if (spi) begin
        io_out <= {1'b0, miso_r, rd_phase, 5'h00};
        io_oe <= 8'h60;
      end else if (rd_phase) begin
        io_out <= shout_r;
        io_oe <= 8'hFF;
      end else if (direct) begin
        io_out <= {1'b0, tx_bit, tx_strobe, 5'h00};
        io_oe <= 8'h60;
      end else begin
        io_out <= 8'h00;
        io_oe <= 8'h00;
      end
      tx_sof <= (ts_r == T_SOF);
      tx_eof <= (ts_r == T_EOF);
      tx_busy <= (ts_r != T_IDLE);
      ext_mod <= regs_r[`A_REG_IO][`IO_EXT_PA_BIT] & tx_bit;
      rx_ext_sel <= regs_r[`A_REG_IO][`IO_EXT_PA_BIT];
      mod_analog <= regs_r[`A_MOD_CTRL][`MOD_ANALOG_BIT];
    end
  end
endmodule // reader_host_port_tx_start

/* File: tb/host_port_monitor.sv */
// checker of the host port pins, bound to the top module
`timescale 1ns/10ps
module host_port_monitor #(
  parameter FIFO_DEPTH = 16,
  parameter TX_BIT_CYC = 8
) (
  input wire core_clk,
  input wire srst,
  input wire data_clk,
  input wire [7:0] io_in,
  input wire [7:0] io_out,
  input wire [7:0] io_oe,
  input wire irq,
  input wire tx_bit,
  input wire tx_strobe,
  input wire tx_sof,
  input wire tx_eof,
  input wire tx_busy,
  input wire ext_mod,
  input wire rx_ext_sel,
  input wire mod_analog
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // strap sampling settles a few edges after release
  property p_oe_spi;
    !$past(srst) && !$past(srst, 2) && !$past(srst, 3) && !$past(srst, 4) |-> io_oe == 8'h60;
  endproperty
  a_oe_spi: assert property (p_oe_spi) else $error("pad enables not spi set");
  property p_ext_mod;
    !rx_ext_sel |-> !ext_mod;
  endproperty
  a_ext_mod: assert property (p_ext_mod) else $error("ext mod without enable");
  // bench runs with no rate shift, so bit periods stay long
  property p_strobe_gap;
    tx_strobe |=> !tx_strobe [*7];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("bit strobes too close");
  property p_strobe_busy;
    tx_strobe |=> tx_busy;
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("bit sent while idle");
  property p_eof_end;
    tx_eof |-> !tx_sof && tx_busy;
  endproperty
  a_eof_end: assert property (p_eof_end) else $error("eof framing wrong");
  property p_irq_end;
    $fell(tx_busy) |-> ##[0:4] irq;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("no irq at tx end");
  property p_ind_ss;
    $rose(io_in[4]) |-> ##[0:6] !io_out[5];
  endproperty
  a_ind_ss: assert property (p_ind_ss) else $error("read flag after deselect");
  property p_ss_quiet;
    io_in[4] [*8] |-> $stable(rx_ext_sel) && $stable(mod_analog);
  endproperty
  a_ss_quiet: assert property (p_ss_quiet) else $error("register moved while deselected");
endmodule // host_port_monitor

bind reader_host_port_tx_start host_port_monitor #(
  .FIFO_DEPTH(FIFO_DEPTH),
  .TX_BIT_CYC(TX_BIT_CYC)
) mon_u (
  .core_clk(core_clk), .srst(srst), .data_clk(data_clk), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .irq(irq), .tx_bit(tx_bit), .tx_strobe(tx_strobe), .tx_sof(tx_sof),
  .tx_eof(tx_eof), .tx_busy(tx_busy), .ext_mod(ext_mod), .rx_ext_sel(rx_ext_sel),
  .mod_analog(mod_analog)
);

/* File: tb/host_mcu_model.sv */
// microcontroller model: spi master with slave select, straps and pad wiring
`timescale 1ns/10ps
module host_mcu_model (
  input wire core_clk,
  input wire [7:0] io_out,
  input wire [7:0] io_oe,
  output logic data_clk,
  output logic [7:0] io_in
);
  logic mosi = 1'b0;
  logic ss_n = 1'b1;
  logic miso_q[$];
  logic ind_q[$];
  initial data_clk = 1'b0;
  // released pads show the inverse of what the device last put out
  assign io_in = {mosi, io_oe[6] ? io_out[6] : ~io_out[6], io_oe[5] ? io_out[5] : ~io_out[5],
                  ss_n, 1'b0, 3'b110};
  ////////////////////////////////////////
  // one bit: fall, set data, rise; pins sampled just before each fall
  task automatic clk_bit(input logic b);
    @(posedge core_clk);
    data_clk <= 1'b0;
    mosi <= b;
    miso_q.push_back(io_in[6]);
    ind_q.push_back(io_in[5]);
    repeat (4) @(posedge core_clk);
    data_clk <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic frame_start;
    @(posedge core_clk);
    ss_n <= 1'b0;
    miso_q.delete();
    ind_q.delete();
    repeat (4) @(posedge core_clk);
  endtask
  task automatic word(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) clk_bit(w[i]);
  endtask
  // clock rests low between frames; data line flips once released
  task automatic frame_end;
    @(posedge core_clk);
    data_clk <= 1'b0;
    miso_q.push_back(io_in[6]);
    ind_q.push_back(io_in[5]);
    repeat (4) @(posedge core_clk);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic get_byte(input int k, output logic [7:0] v);
    for (int j = 0; j < 8; j++) v[7-j] = miso_q[9+8*k+j];
  endtask
endmodule // host_mcu_model

/* File: tb/tb.sv */
// top-level bench: spi host traffic, register checks and transmit start
`timescale 1ns/10ps
`include "host_port_defines.vh"
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  wire data_clk;
  wire [7:0] io_in;
  wire [7:0] io_out;
  wire [7:0] io_oe;
  wire irq, tx_bit, tx_strobe, tx_sof, tx_eof, tx_busy, ext_mod, rx_ext_sel, mod_analog;
  int fail_count = 0;
  int tests_run = 0;
  logic bits_q[$];
  logic [7:0] v;
  reader_host_port_tx_start #(.FIFO_DEPTH(16), .TX_BIT_CYC(32)) dut_u (
    .core_clk(core_clk), .srst(srst), .data_clk(data_clk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .irq(irq), .tx_bit(tx_bit), .tx_strobe(tx_strobe), .tx_sof(tx_sof),
    .tx_eof(tx_eof), .tx_busy(tx_busy), .ext_mod(ext_mod), .rx_ext_sel(rx_ext_sel),
    .mod_analog(mod_analog)
  );
  host_mcu_model host_u (
    .core_clk(core_clk), .io_out(io_out), .io_oe(io_oe), .data_clk(data_clk), .io_in(io_in)
  );
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // every strobed bit, parity and CRC included; framing periods left out
  always @(posedge core_clk) begin
    if (tx_strobe === 1'b1 && tx_sof === 1'b0 && tx_eof === 1'b0) bits_q.push_back(tx_bit);
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // lowest byte of d (d[7:0]) goes out first
  task automatic wr(input logic [4:0] a, input logic cont, input int n, input logic [63:0] d);
    host_u.frame_start();
    host_u.word({2'b00, cont, a});
    for (int i = 0; i < n; i++) host_u.word(d[8*i+:8]);
    host_u.frame_end();
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    host_u.frame_start();
    host_u.word({3'b010, a});
    host_u.word(8'h00);
    host_u.frame_end();
    host_u.get_byte(0, r);
    check(host_u.ind_q[4], 1'b0, "read flag in address");
    check(host_u.ind_q[12], 1'b1, "read flag in data");
  endtask
  task automatic cmd(input logic [4:0] c);
    host_u.frame_start();
    host_u.word({3'b100, c});
    host_u.frame_end();
  endtask
  task automatic tx_done(input int nbits, input logic [7:0] b0, input logic [7:0] st);
    int t;
    logic [7:0] f;
    t = 0;
    while (tx_busy !== 1'b1 && t < 400) begin
      @(posedge core_clk);
      t++;
    end
    while (tx_busy === 1'b1 && t < 6000) begin
      @(posedge core_clk);
      t++;
    end
    for (int i = 0; i < 8; i++) f[i] = bits_q[i];
    check(bits_q.size(), nbits, "payload bits");
    check(f, b0, "first byte lsb first");
    repeat (4) @(posedge core_clk);
    check(irq, 1'b1, "irq at end");
    rd(`A_IRQ_STAT, v);
    check(v, st, "tx complete flag");
    rd(`A_IRQ_STAT, v);
    check(v, 8'h00, "flag cleared by read");
  endtask
  ////////////////////////////////////////
  task automatic s_regs;
    rd(`A_TX_LEN_HI, v);
    check(v, 8'h00, "len hi reset");
    wr(`A_TX_LEN_HI, 1'b1, 2, 64'h5AA5);
    rd(`A_TX_LEN_HI, v);
    check(v, 8'hA5, "cont first");
    rd(`A_TX_LEN_LO, v);
    check(v, 8'h5A, "cont second");
    wr(`A_OPT_B, 1'b0, 2, 64'h0C04);
    rd(`A_OPT_HBR, v);
    check(v, 8'h00, "single mode extra word");
    wr(`A_IRQ_STAT, 1'b0, 1, 64'hFF);
    rd(`A_IRQ_STAT, v);
    check(v, 8'h00, "status not writable");
    wr(`A_OPT_B, 1'b1, 2, 64'h010C);
    wr(`A_ISO_CTRL, 1'b0, 1, 64'h00);
    rd(`A_OPT_B, v);
    check(v, `PRESET_OPT_B, "preset b");
    rd(`A_OPT_HBR, v);
    check(v, `PRESET_OPT_HBR, "preset hbr");
  endtask
  task automatic s_io;
    host_u.word({3'b000, `A_REG_IO});
    host_u.word(8'h40);
    host_u.frame_end();
    check(rx_ext_sel, 1'b0, "clocks while deselected");
    wr(`A_REG_IO, 1'b0, 1, 64'h40);
    wr(`A_MOD_CTRL, 1'b0, 1, 64'h08);
    check(rx_ext_sel, 1'b1, "external path on");
    check(mod_analog, 1'b1, "analog pin");
    wr(`A_REG_IO, 1'b1, 1, 64'h00);
    wr(`A_MOD_CTRL, 1'b0, 1, 64'h00);
    check({rx_ext_sel, mod_analog}, 2'b00, "both off");
  endtask
  task automatic s_tx_late;
    cmd(`CMD_FIFO_RESET);
    wr(`A_OPT_HBR, 1'b0, 1, 64'h01);
    wr(`A_TX_LEN_HI, 1'b1, 3, 64'h3C1000);
    repeat (100) @(posedge core_clk);
    check(tx_busy, 1'b0, "no start before command");
    bits_q.delete();
    cmd(`CMD_TRANSMIT);
    tx_done(24, 8'h3C, 8'h80);
  endtask
  task automatic s_tx_early;
    cmd(`CMD_FIFO_RESET);
    cmd(`CMD_TRANSMIT);
    wr(`A_TX_LEN_HI, 1'b1, 2, 64'h1700);
    repeat (100) @(posedge core_clk);
    check(tx_busy, 1'b0, "waits for data");
    bits_q.delete();
    wr(`A_FIFO, 1'b1, 2, 64'hC381);
    // two units owed with one queued at start, so the fifo low flag is up too
    tx_done(27, 8'h81, 8'hA0);
  endtask
  task automatic s_tx_long;
    int t;
    t = 0;
    cmd(`CMD_FIFO_RESET);
    wr(`A_TX_LEN_HI, 1'b1, 7, 64'h1122334455_6000);
    bits_q.delete();
    cmd(`CMD_TRANSMIT);
    while (irq !== 1'b1 && t < 2000) begin
      @(posedge core_clk);
      t++;
    end
    rd(`A_IRQ_STAT, v);
    check(v & 8'h20, 8'h20, "fifo low flag");
    wr(`A_FIFO, 1'b0, 1, 64'h66);
    tx_done(64, 8'h55, 8'h80);
  endtask
  ////////////////////////////////////////
  initial begin
    #(60000 * 50);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    repeat (6) @(posedge core_clk);
    s_regs();
    s_io();
    s_tx_late();
    s_tx_early();
    s_tx_long();
    stop_test();
  end
endmodule // tb
